// File: rtl/fbi_params.svh
`ifndef FBI_PARAMS_SVH
`define FBI_PARAMS_SVH
// Summary of operation
// - Reads drive chip enables and output enable low, write enable and reset high.
// - Eight-word pages must be re-enabled by command after every reset.
// - Host writes read-array command before array reads following other operations; after a reset operation the code reads without it.
// - Set-configuration is two writes, 0060h then 0004h, value on A[15:0].
// - Host issues clear-status after set-configuration when eight-word pages used.
// - Config bit 13 selects eight-word pages; all other bits written zero. The code sends all 16 config register bits as written, unmasked.
// - Never assert output enable and write enable together; read wins.

// Register offsets
`define FBI_OFF_CTRL     8'h00
`define FBI_OFF_ADDR     8'h04
`define FBI_OFF_WDATA    8'h08
`define FBI_OFF_CFG      8'h0c
`define FBI_OFF_RDATA    8'h10
`define FBI_OFF_STAT     8'h14
// Field positions
`define FBI_CTRL_GO      0
`define FBI_CTRL_OP_LSB  1
`define FBI_CTRL_WIDE    3
`define FBI_CFG_PAGE8    13
// Reset values
`define FBI_CFG_RST      16'h0000
`define FBI_ADDR_RST     24'h000000
// Command words and chip enable patterns
`define FBI_CMD_RD_ARRAY 16'h00ff
`define FBI_CMD_CFG_SET  16'h0060
`define FBI_CMD_CFG_CONF 16'h0004
`define FBI_CMD_CLR_STAT 16'h0050
`define FBI_CE_ON        3'h0
`define FBI_CE_OFF       3'h7
// Timing in ns and derived cycle counts (least times, rounded up)
`define FBI_CLK_NS       50
`define FBI_INIT_ACC_NS  100
`define FBI_PAGE_ACC_NS  30
`define FBI_WR_SETUP_NS  50
`define FBI_WE_PULSE_NS  60
`define FBI_WR_HOLD_NS   50
`define FBI_RST_LOW_NS   25000
`define FBI_WAKE_NS      200
`define FBI_CYC(ns)      (((ns) + `FBI_CLK_NS - 1) / `FBI_CLK_NS)
`define FBI_SYNC_LAG     3
`define FBI_INIT_CYC     (`FBI_CYC(`FBI_INIT_ACC_NS) + `FBI_SYNC_LAG)
`define FBI_PAGE_CYC     (`FBI_CYC(`FBI_PAGE_ACC_NS) + `FBI_SYNC_LAG)
`define FBI_SETUP_CYC    `FBI_CYC(`FBI_WR_SETUP_NS)
`define FBI_WE_CYC       `FBI_CYC(`FBI_WE_PULSE_NS)
`define FBI_HOLD_CYC     `FBI_CYC(`FBI_WR_HOLD_NS)
`define FBI_RST_CYC      `FBI_CYC(`FBI_RST_LOW_NS)
`define FBI_WAKE_CYC     `FBI_CYC(`FBI_WAKE_NS)
`endif

// File: rtl/fbi_pkg.sv
package fbi_pkg;
    // Operations started from the control register
    typedef enum logic [1:0] {
        OP_READ  = 2'h0,
        OP_WRITE = 2'h1,
        OP_CFG   = 2'h2,
        OP_RESET = 2'h3
    } fbi_op_t;

    // Pin sequencer states, Gray along the write path and from write hold into read wait
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_WSETUP  = 3'h1,
        ST_WPULSE  = 3'h3,
        ST_WHOLD   = 3'h2,
        ST_RWAIT   = 3'h6,
        ST_RLATCH  = 3'h7,
        ST_RSTLOW  = 3'h5,
        ST_RSTWAKE = 3'h4
    } fbi_state_t;

    // Flash pins driven by the controller
    typedef struct packed {
        logic        rpN;
        logic [2:0]  chipSel;
        logic        oeN;
        logic        weN;
        logic        wide;
        logic [23:0] addr;
        logic [15:0] dq;
        logic        dqOe;
    } fbi_pins_t;
endpackage

// File: rtl/fbi_pin_sync.sv
`timescale 1ns/100ps
module fbi_pin_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Pin side and synchronised side
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] syncOut
);
    // ------------------------------------------------------------
    // Two flip-flops per bit
    // ------------------------------------------------------------
    logic [WIDTH-1:0] firstReg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (rst) begin
                    firstReg[i] <= 1'b0;
                    syncOut[i]  <= 1'b0;
                end else begin
                    firstReg[i] <= pinIn[i];
                    syncOut[i]  <= firstReg[i];
                end
            end
        end
    endgenerate
endmodule // fbi_pin_sync

// File: rtl/fbi_host_ctrl.sv
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "fbi_params.svh"
module fbi_host_ctrl import fbi_pkg::*; (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Flash pins
    output fbi_pins_t        pinOut,
    input  wire logic [15:0] dqIn
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    fbi_state_t  stateReg, stateNext;
    fbi_op_t     opReg;
    logic [11:0] cntReg, cntNext;
    logic [1:0]  stepReg, stepNext;
    logic [23:0] addrReg, tagReg;
    logic [15:0] wdataReg, cfgReg, rdataReg, dqSync;
    logic        wideReg, page8Reg, needRaReg, pageOpenReg, doneReg;
    logic        wrEnReg, finish, latch;
    logic [7:0]  wrOffReg;
    logic [31:0] hrdataReg, rdMux;
    fbi_pins_t   pinReg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Address phase accepted; slave never waits and always answers OKAY
    wire        addrPhase = hsel & hready & htrans[1];
    wire        busy      = (stateReg != ST_IDLE);
    wire        wrCtrl    = wrEnReg & (wrOffReg == `FBI_OFF_CTRL);
    wire        wrAddr    = wrEnReg & (wrOffReg == `FBI_OFF_ADDR);
    wire        wrData    = wrEnReg & (wrOffReg == `FBI_OFF_WDATA);
    wire        wrCfg     = wrEnReg & (wrOffReg == `FBI_OFF_CFG);
    wire        goPulse   = wrCtrl & hwdata[`FBI_CTRL_GO] & ~busy;
    wire [1:0]  goOp      = hwdata[`FBI_CTRL_OP_LSB +: 2];
    wire [31:0] statWord  = {28'h0000000, needRaReg, page8Reg, doneReg, busy};
    wire [31:0] ctrlWord  = {28'h0000000, wideReg, opReg, 1'b0};

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdataReg;

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        case (haddr[7:0])
            `FBI_OFF_CTRL:  rdMux = ctrlWord;
            `FBI_OFF_ADDR:  rdMux = {8'h00, addrReg};
            `FBI_OFF_WDATA: rdMux = {16'h0000, wdataReg};
            `FBI_OFF_CFG:   rdMux = {16'h0000, cfgReg};
            `FBI_OFF_RDATA: rdMux = {16'h0000, rdataReg};
            `FBI_OFF_STAT:  rdMux = statWord;
            default:        rdMux = 32'h00000000;
        endcase
    end

    // Address phase capture and read data
    always_ff @(posedge clock) begin
        if (rst) begin
            wrEnReg   <= 1'b0;
            wrOffReg  <= 8'h00;
            hrdataReg <= 32'h00000000;
        end else begin
            wrEnReg  <= addrPhase & hwrite;
            wrOffReg <= haddr[7:0];
            if (addrPhase & ~hwrite) begin
                hrdataReg <= rdMux;
            end
        end
    end

    // Software registers, held steady while an operation runs
    always_ff @(posedge clock) begin
        if (rst) begin
            addrReg  <= `FBI_ADDR_RST;
            wdataReg <= 16'h0000;
            cfgReg   <= `FBI_CFG_RST;
        end else if (~busy) begin
            if (wrAddr) addrReg <= hwdata[23:0];
            if (wrData) wdataReg <= hwdata[15:0];
            if (wrCfg) cfgReg <= hwdata[15:0];
        end
    end

    // Operation and width select, taken from a control write while idle
    always_ff @(posedge clock) begin
        if (rst) begin
            opReg   <= OP_READ;
            wideReg <= 1'b1;
        end else if (wrCtrl & ~busy) begin
            opReg   <= fbi_op_t'(goOp);
            wideReg <= hwdata[`FBI_CTRL_WIDE];
        end
    end

    // ------------------------------------------------------------
    // Data pin synchroniser
    // ------------------------------------------------------------
    fbi_pin_sync #(
        .WIDTH   (16)
    ) u_sync (
        .clock   (clock),
        .rst     (rst),
        .pinIn   (dqIn),
        .syncOut (dqSync)
    );

    // ------------------------------------------------------------
    // Command words and page tracking
    // ------------------------------------------------------------
    // Set-configuration steps: setup, confirm, then clear status
    wire [15:0] cfgWord = (stepReg == 2'd0) ? `FBI_CMD_CFG_SET :
                          (stepReg == 2'd1) ? `FBI_CMD_CFG_CONF : `FBI_CMD_CLR_STAT;
    wire [15:0] cmdData = (opReg == OP_READ)  ? `FBI_CMD_RD_ARRAY :
                          (opReg == OP_WRITE) ? wdataReg : cfgWord;
    // Configuration value rides on A[15:0] for both cycles
    wire [23:0] cmdAddr = (opReg == OP_CFG) ? {8'h00, cfgReg} : addrReg;
    wire        lastStep = (opReg != OP_CFG) | (stepReg == 2'd2) |
                           ((stepReg == 2'd1) & ~cfgReg[`FBI_CFG_PAGE8]);
    // Same page when bits above the page are unchanged and CE held low
    wire        samePage = page8Reg ? (addrReg[23:4] == tagReg[23:4])
                                    : (addrReg[23:3] == tagReg[23:3]);
    wire        pageHit  = pageOpenReg & samePage;
    wire [11:0] rdWait   = pageHit ? 12'(`FBI_PAGE_CYC) : 12'(`FBI_INIT_CYC);

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        stateNext = stateReg;
        cntNext   = (cntReg != 12'h000) ? cntReg - 12'h001 : cntReg;
        stepNext  = stepReg;
        finish    = 1'b0;
        latch     = 1'b0;
        case (stateReg)
            ST_IDLE: begin
                if (goPulse) begin
                    stepNext = 2'd0;
                    cntNext  = 12'(`FBI_SETUP_CYC);
                    stateNext = ST_WSETUP;
                    if (goOp == OP_RESET) begin
                        stateNext = ST_RSTLOW;
                        cntNext   = 12'(`FBI_RST_CYC);
                    end else if ((goOp == OP_READ) & ~needRaReg) begin
                        stateNext = ST_RWAIT;
                        cntNext   = rdWait;
                    end
                end
            end
            ST_WSETUP: begin
                if (cntReg == 12'h000) begin
                    stateNext = ST_WPULSE;
                    cntNext   = 12'(`FBI_WE_CYC);
                end
            end
            ST_WPULSE: begin
                if (cntReg == 12'h000) begin
                    stateNext = ST_WHOLD;
                    cntNext   = 12'(`FBI_HOLD_CYC);
                end
            end
            ST_WHOLD: begin
                if (cntReg == 12'h000) begin
                    if (opReg == OP_READ) begin
                        stateNext = ST_RWAIT;
                        cntNext   = 12'(`FBI_INIT_CYC);
                    end else if (lastStep) begin
                        stateNext = ST_IDLE;
                        finish    = 1'b1;
                    end else begin
                        stepNext  = stepReg + 2'd1;
                        stateNext = ST_WSETUP;
                        cntNext   = 12'(`FBI_SETUP_CYC);
                    end
                end
            end
            ST_RWAIT: begin
                if (cntReg == 12'h000) begin
                    stateNext = ST_RLATCH;
                end
            end
            ST_RLATCH: begin
                stateNext = ST_IDLE;
                finish    = 1'b1;
                latch     = 1'b1;
            end
            ST_RSTLOW: begin
                if (cntReg == 12'h000) begin
                    stateNext = ST_RSTWAKE;
                    cntNext   = 12'(`FBI_WAKE_CYC);
                end
            end
            ST_RSTWAKE: begin
                if (cntReg == 12'h000) begin
                    stateNext = ST_IDLE;
                    finish    = 1'b1;
                end
            end
            default: stateNext = ST_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock) begin
        if (rst) begin
            stateReg <= ST_IDLE;
            cntReg   <= 12'h000;
            stepReg  <= 2'd0;
        end else begin
            stateReg <= stateNext;
            cntReg   <= cntNext;
            stepReg  <= stepNext;
        end
    end

    // Completion flag, cleared by the next start
    always_ff @(posedge clock) begin
        if (rst) begin
            doneReg <= 1'b0;
        end else if (finish) begin
            doneReg <= 1'b1;
        end else if (goPulse) begin
            doneReg <= 1'b0;
        end
    end

    // Read mode tracking: array mode is only trusted after read-array or a device reset
    always_ff @(posedge clock) begin
        if (rst) begin
            needRaReg <= 1'b1;
        end else if ((stateReg == ST_WHOLD) & (stateNext == ST_RWAIT)) begin
            needRaReg <= 1'b0;
        end else if (finish & (opReg != OP_READ)) begin
            needRaReg <= (opReg != OP_RESET);
        end
    end

    // Page length mirror of the device configuration word
    always_ff @(posedge clock) begin
        if (rst) begin
            page8Reg <= 1'b0;
        end else if (stateReg == ST_RSTLOW) begin
            page8Reg <= 1'b0;
        end else if (finish & (opReg == OP_CFG)) begin
            page8Reg <= cfgReg[`FBI_CFG_PAGE8];
        end
    end

    // Open page and captured word; any write or deselect closes the page
    always_ff @(posedge clock) begin
        if (rst) begin
            pageOpenReg <= 1'b0;
            tagReg      <= 24'h000000;
            rdataReg    <= 16'h0000;
        end else if (latch) begin
            pageOpenReg <= 1'b1;
            tagReg      <= addrReg;
            rdataReg    <= wideReg ? dqSync : {8'h00, dqSync[7:0]};
        end else if ((stateReg == ST_WSETUP) | (stateReg == ST_RSTLOW)) begin
            pageOpenReg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin drive, registered from the current state
    // ------------------------------------------------------------
    wire inWrite = (stateReg == ST_WSETUP) | (stateReg == ST_WPULSE) | (stateReg == ST_WHOLD);
    wire inRead  = (stateReg == ST_RWAIT) | (stateReg == ST_RLATCH);
    wire ceOn    = inWrite | inRead | ((stateReg == ST_IDLE) & pageOpenReg);

    always_comb begin
        pinReg.rpN     = (stateReg != ST_RSTLOW);
        pinReg.chipSel = ceOn ? `FBI_CE_ON : `FBI_CE_OFF;
        pinReg.oeN     = ~inRead;
        pinReg.weN     = (stateReg != ST_WPULSE);
        pinReg.wide    = wideReg;
        pinReg.addr    = inWrite ? cmdAddr : addrReg;
        pinReg.dq      = cmdData;
        pinReg.dqOe    = inWrite;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pinOut <= '{rpN: 1'b1, chipSel: `FBI_CE_OFF, oeN: 1'b1, weN: 1'b1,
                        wide: 1'b1, addr: 24'h000000, dq: 16'h0000, dqOe: 1'b0};
        end else begin
            pinOut <= pinReg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int RstCycInt = `FBI_RST_CYC;
    logic [11:0] lowCntReg;

    // Counts cycles of reset pin low, saturating
    always_ff @(posedge clock) begin
        if (rst | pinOut.rpN) begin
            lowCntReg <= 12'h000;
        end else if (lowCntReg != 12'hfff) begin
            lowCntReg <= lowCntReg + 12'h001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_oe_we_excl: assert property (!(~pinOut.oeN & ~pinOut.weN))
        else $error("output enable and write enable low together");
    chk_read_pins: assert property (~pinOut.oeN |-> pinOut.weN & pinOut.rpN & ~pinOut.dqOe)
        else $error("read cycle with write, reset or drive active");
    chk_we_enabled: assert property (~pinOut.weN |-> pinOut.chipSel == `FBI_CE_ON)
        else $error("write enable low while device deselected");
    chk_we_rise_hold: assert property ($rose(pinOut.weN) |-> $stable(pinOut.addr)
        and $stable(pinOut.dq) ##1 pinOut.dqOe)
        else $error("address or data moved at write enable rise");
    chk_reset_width: assert property ($rose(pinOut.rpN) |-> lowCntReg >= RstCycInt)
        else $error("reset pin low pulse too short");
    chk_page_default: assert property ($rose(pinOut.rpN) |-> ~page8Reg)
        else $error("page length not back to four words after reset");
    chk_cfg_confirm: assert property ((stateReg == ST_WPULSE) & (opReg == OP_CFG)
        & (stepReg == 2'd1) |=> (pinOut.dq == `FBI_CMD_CFG_CONF)
        & (pinOut.addr[15:0] == cfgReg) & ~pinOut.weN)
        else $error("confirm cycle of set-configuration malformed");
    chk_clear_status: assert property ((stateReg == ST_WPULSE) & (opReg == OP_CFG)
        & (stepReg == 2'd2) |-> cfgReg[`FBI_CFG_PAGE8])
        else $error("clear-status sent without eight-word request");
    chk_read_array: assert property ((stateReg == ST_RWAIT) |-> ~needRaReg)
        else $error("array read without read-array command");
    chk_page_switch: assert property ($changed(page8Reg) |-> $past(finish)
        | $past(stateReg == ST_RSTLOW))
        else $error("page length changed outside configuration or reset");

    cov_cfg_eight: cover property (finish & (opReg == OP_CFG) & cfgReg[`FBI_CFG_PAGE8]);
    cov_page_hit: cover property (goPulse & (goOp == OP_READ) & pageHit);
    cov_reset_op: cover property (finish & (opReg == OP_RESET));
endmodule // fbi_host_ctrl

// File: verif/fbi_flash_model.sv
`timescale 1ns/100ps
module fbi_flash_model import fbi_pkg::*; (
    // Pins from the controller, progEn from the testbench
    input  wire fbi_pins_t   pins,
    input  wire logic        progEn,
    // Data pins back to the controller
    output logic      [15:0] dqOut
);
    // ------------------------------------------------------------
    // Array, page length word and command state
    // ------------------------------------------------------------
    logic [15:0] mem [32];
    logic [15:0] cfgReg;
    logic [15:0] lastCmd;
    logic [15:0] lastOut;
    logic [15:0] word;
    logic [15:0] val;
    logic        en;
    logic        drive;

    // Device selected by the chip enable set
    assign en = (pins.chipSel == 3'h0) || (pins.chipSel[2] && !(&pins.chipSel[1:0]));
    // Array word in read mode, one status word otherwise
    assign word = (lastCmd == 16'h00ff) ? mem[pins.addr[5:1]] : 16'h0080;
    assign val = pins.wide ? word : {8'h00, pins.addr[0] ? word[15:8] : word[7:0]};
    // Output enable wins over write enable; inverse of last value when off
    assign drive = en && pins.rpN && !pins.oeN;

    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
        cfgReg = 16'h0000;
        lastCmd = 16'h00ff;
        lastOut = 16'h0000;
    end

    // Command decode on each captured write
    task automatic latchCmd;
        if (!pins.rpN || !pins.oeN) return;
        if (lastCmd == 16'h0060 && pins.dq == 16'h0004) cfgReg = pins.addr[15:0];
        else if (lastCmd == 16'h0040 && progEn) mem[pins.addr[5:1]] &= pins.dq;
        else if (lastCmd == 16'h0020 && pins.dq == 16'h00d0 && progEn) begin
            foreach (mem[i]) if (i[4] == pins.addr[5]) mem[i] = 16'hffff;
        end
        // Two-cycle commands fall back to read mode
        if (lastCmd == 16'h0060 || lastCmd == 16'h0040 || lastCmd == 16'h0020) begin
            lastCmd = 16'h00ff;
        end else begin
            lastCmd = pins.dq;
        end
    endtask

    // Capture on write enable rise or deselect, whichever is first
    always @(posedge pins.weN) if (en) latchCmd();
    always @(negedge en) if (!pins.weN) latchCmd();
    // Volatile page length word, four-word pages after reset
    always @(posedge pins.rpN) begin
        cfgReg = 16'h0000;
        lastCmd = 16'h00ff;
    end
    // Released lines show the inverse of the last driven value
    always @(val or drive) if (drive) lastOut = val;
    assign dqOut = drive ? val : ~lastOut;
endmodule // fbi_flash_model

// File: verif/fbi_host_ctrl_tb.sv
`timescale 1ns/100ps
module fbi_host_ctrl_tb import fbi_pkg::*;;
    // ------------------------------------------------------------
    // Stimulus, rows and counters
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  off;
        logic [31:0] exp;
    } fbi_row_t;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        progEn = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] q;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [15:0] dqIn;
    fbi_pins_t   pinOut;
    int          errCount = 0;
    int          checks = 0;
    fbi_row_t    rows [7] = '{'{8'h00, 32'h8}, '{8'h04, 32'h0}, '{8'h08, 32'h0},
        '{8'h0c, 32'h0}, '{8'h10, 32'h0}, '{8'h14, 32'h8}, '{8'h18, 32'h0}};

    // Clock
    always #25 clock = ~clock;

    fbi_host_ctrl DUT (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pinOut(pinOut), .dqIn(dqIn));
    fbi_flash_model flash (.pins(pinOut), .progEn(progEn), .dqOut(dqIn));

    // ------------------------------------------------------------
    // Bus and operation tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // Start an operation and poll until done with busy low
    task automatic go(input logic [1:0] o, input logic w);
        int n;
        n = 0;
        ahb(1'b1, 8'h00, {28'h0, w, o, 1'b1});
        do begin
            ahb(1'b0, 8'h14, 32'h0);
            n++;
        end while (q[1:0] !== 2'b10 && n < 1000);
        chk({30'h0, q[1:0]}, 32'h2);
    endtask
    task automatic prog(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, 8'h04, a);
        ahb(1'b1, 8'h08, d);
        go(2'h1, 1'b1);
    endtask
    task automatic rdFlash(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b1, 8'h04, a);
        go(2'h0, 1'b1);
        ahb(1'b0, 8'h10, 32'h0);
        chk(q, exp);
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", checks, errCount);
        if (errCount == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i]) begin
            ahb(1'b0, rows[i].off, 32'h0);
            chk(q, rows[i].exp);
        end
        prog(32'h10, 32'h40);
        prog(32'h10, 32'h1234);
        rdFlash(32'h10, 32'h1234);
        chk({25'h0, hresp, pinOut.chipSel, pinOut.dqOe, pinOut.oeN, pinOut.weN}, 32'h3);
        // Byte lanes: odd byte of the word just programmed
        ahb(1'b1, 8'h04, 32'h11);
        go(2'h0, 1'b0);
        ahb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h12);
        rdFlash(32'h12, 32'hffff);
        prog(32'h10, 32'h40);
        prog(32'h10, 32'h0f0f);
        rdFlash(32'h10, 32'h0204);
        progEn <= 1'b0;
        prog(32'h10, 32'h40);
        prog(32'h10, 32'h0);
        rdFlash(32'h10, 32'h0204);
        progEn <= 1'b1;
        prog(32'h10, 32'h20);
        prog(32'h10, 32'hd0);
        rdFlash(32'h10, 32'hffff);
        ahb(1'b1, 8'h0c, 32'h2000);
        go(2'h2, 1'b1);
        ahb(1'b0, 8'h14, 32'h0);
        chk(q & 32'h4, 32'h4);
        chk({16'h0, flash.cfgReg}, 32'h2000);
        chk({16'h0, flash.lastCmd}, 32'h50);
        rdFlash(32'h12, 32'hffff);
        go(2'h3, 1'b1);
        ahb(1'b0, 8'h14, 32'h0);
        chk(q & 32'hc, 32'h0);
        chk({16'h0, flash.cfgReg}, 32'h0);
        chk({29'h0, pinOut.chipSel}, 32'h7);
        // Four-word request: two cycles only, no clear-status
        ahb(1'b1, 8'h0c, 32'h0);
        go(2'h2, 1'b1);
        ahb(1'b0, 8'h14, 32'h0);
        chk(q & 32'h4, 32'h0);
        chk({16'h0, flash.lastCmd}, 32'hff);
        rdFlash(32'h10, 32'hffff);
        // Reset in mid-run returns registers and pins to idle
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        ahb(1'b0, 8'h14, 32'h0);
        chk(q, 32'h8);
        ahb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0);
        chk({29'h0, pinOut.chipSel}, 32'h7);
        summarize();
    end

    // Watchdog
    initial begin
        #(20000 * 50);
        errCount++;
        summarize();
    end
endmodule // fbi_host_ctrl_tb
